//--- design/hcop_params.svh
`ifndef HCOP_PARAMS_SVH
`define HCOP_PARAMS_SVH

// Pin counts and field widths
`define HCOP_GPIO_N 7
`define HCOP_DIV_W 10
`define HCOP_SLEW_W 4

// Slew select bit positions
`define HCOP_SLEW_IRQ 0
`define HCOP_SLEW_CLK 1
`define HCOP_SLEW_MISO 2
`define HCOP_SLEW_GPIO 3

// Status function select bit positions
`define HCOP_FUNC_ACT 0
`define HCOP_FUNC_CRC 1

// Reset values of the configuration and the divide limit
`define HCOP_DIV_RESET 10'h1e8
`define HCOP_DIV_MAX 10'h3d0
`define HCOP_GPIO_DIR_RESET 7'h00
`define HCOP_GPIO_OUT_RESET 7'h00
`define HCOP_FUNC_RESET 2'h0
`define HCOP_SLEW_RESET 4'h0
`define HCOP_CLK_EN_RESET 1'b1
`define HCOP_KEEP_RESET 1'b0
`define HCOP_PULLUP_RESET 1'b1

// Start-up interval: a time in ms and the clock rate in MHz
`define HCOP_STARTUP_MS 20
`define HCOP_REF_MHZ 250
`define HCOP_STARTUP_CYCLES (`HCOP_STARTUP_MS * `HCOP_REF_MHZ * 1000)

`endif

//--- design/hcop_pkg.sv
package hcop_pkg;
  `include "hcop_params.svh"

  // Power and start-up sequencing states
  typedef enum logic [2:0] {
    HCOP_ST_STARTUP = 3'b001,
    HCOP_ST_IDLE = 3'b010,
    HCOP_ST_SLEEP = 3'b100
  } hcop_state_e;

  typedef logic [`HCOP_GPIO_N-1:0] hcop_gpio_t;
  typedef logic [`HCOP_DIV_W-1:0] hcop_div_t;
endpackage

//--- design/hcop_if.sv
`timescale 1ns/100ps
// Settings handed from the control domain to the clock divider
interface hcop_if #(
  parameter int DIV_W = 10
);
  logic [DIV_W-1:0] div_value;
  logic run;
  logic req_tgl;
  logic ack_tgl;

  modport src (
    output div_value,
    output run,
    output req_tgl,
    input ack_tgl
  );

  modport sink (
    input div_value,
    input run,
    input req_tgl,
    output ack_tgl
  );
endinterface

//--- design/hcop_clkdiv.sv
`timescale 1ns/100ps
`include "hcop_params.svh"
module hcop_clkdiv
  import hcop_pkg::*;
#(
  parameter int DIV_W = 10
) (
  // Link clock and control reset
  input wire logic xtal_clk,
  input wire logic rst,
  // Settings from the control domain
  hcop_if.sink cfg,
  // Clock pin
  output logic host_clock_output
);
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rq_s1_reg;
  logic rq_s2_reg;
  logic rq_s3_reg;
  logic ack_reg;
  logic [DIV_W-1:0] cap_div_reg;
  logic cap_run_reg;
  logic [DIV_W-1:0] act_div_reg;
  logic act_run_reg;
  logic [DIV_W-1:0] cnt_reg;
  logic out_reg;
  logic pass_en_reg;
  logic boundary;
  logic [DIV_W-1:0] cnt_next;
  logic [DIV_W-1:0] div_sel;
  logic run_sel;
  logic out_next;

  // Reset and request toggle brought onto the link clock
  always_ff @(posedge xtal_clk) begin
    rst_s1_reg <= rst;
    rst_s2_reg <= rst_s1_reg;
    rq_s1_reg <= cfg.req_tgl;
    rq_s2_reg <= rq_s1_reg;
    rq_s3_reg <= rq_s2_reg;
  end

  // Capture settings; the source holds them until it sees the ack
  always_ff @(posedge xtal_clk) begin
    if (rst_s2_reg) begin
      cap_div_reg <= DIV_W'(`HCOP_DIV_RESET);
      cap_run_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (rq_s2_reg != rq_s3_reg) begin
      cap_div_reg <= cfg.div_value;
      cap_run_reg <= cfg.run;
      ack_reg <= rq_s2_reg;
    end
  end
  assign cfg.ack_tgl = ack_reg;

  // New settings take effect only at the end of a whole output period
  assign boundary = ({1'b0, cnt_reg} + {{DIV_W{1'b0}}, 1'b1}) >= {1'b0, act_div_reg}; // R17
  assign cnt_next = boundary ? '0 : cnt_reg + 1'b1;
  assign div_sel = boundary ? cap_div_reg : act_div_reg; // R17
  assign run_sel = boundary ? cap_run_reg : act_run_reg; // R17
  assign out_next = run_sel && (div_sel > DIV_W'(1)) && (cnt_next < (div_sel >> 1)); // R1

  // Divider counter and output level
  always_ff @(posedge xtal_clk) begin
    if (rst_s2_reg) begin
      act_div_reg <= DIV_W'(`HCOP_DIV_RESET); // R3
      act_run_reg <= 1'b0; // R5
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      act_div_reg <= div_sel;
      act_run_reg <= run_sel;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  // Divide by one gates the reference; enable moves while it is low
  always_ff @(negedge xtal_clk) begin
    if (rst_s2_reg) begin
      pass_en_reg <= 1'b0;
    end else begin
      pass_en_reg <= act_run_reg && (act_div_reg == DIV_W'(1));
    end
  end

  // Full rate comes from the gate, lower rates from the flop
  assign host_clock_output = (xtal_clk & pass_en_reg) | out_reg; // R1
endmodule // hcop_clkdiv

//--- design/hcop_top.sv
`timescale 1ns/100ps
`include "hcop_params.svh"
// Notes on behaviour
// [R1] Clock output programmable from the 16 MHz reference, divide 1 to 976.
// [R2] Start-up interrupt raised a fixed interval after reset release.
// [R3] After reset the clock output is enabled at the default 488 divide.
// [R4] Host pulses reset, waits for interrupt, reprograms, waits for lock.
// [R5] Clock output stopped in reset and until start-up interval ends.
// [R6] Light sleep keeps the clock output only when software chose so.
// [R7] Seven general pins, all high-impedance inputs right after reset.
// [R8] No internal pull-up on any general pin.
// [R9] Host should turn unused general pins into outputs driven low.
// [R10] Pins one and two selectable to status functions by software.
// [R11] Direction, level and function of every pin come from written registers.
// [R12] Interrupt output is open drain with a software pull-up enable.
// [R13] Software selects slew for interrupt, clock, serial data, general pins.
// [R14] Interrupt stays asserted until the status register is read.
// [R15] Pin one status shows activity during receive, transmit or assessment.
// [R16] Pin two status shows the frame check result of a receive.
// [R17] New clock divide applied only at an output period boundary.
module hcop_top
  import hcop_pkg::*;
#(
  parameter int GPIO_N = `HCOP_GPIO_N,
  parameter int DIV_W = `HCOP_DIV_W,
  parameter int STARTUP_CYCLES = `HCOP_STARTUP_CYCLES
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic xtal_clk,
  // Configuration written by the command channel
  input wire logic cfg_wr,
  input wire logic [GPIO_N-1:0] cfg_gpio_dir,
  input wire logic [GPIO_N-1:0] cfg_gpio_out,
  input wire logic [1:0] cfg_gpio_func,
  input wire logic [DIV_W-1:0] cfg_clk_div,
  input wire logic cfg_clk_en,
  input wire logic cfg_sleep_keep,
  input wire logic cfg_irq_pullup,
  input wire logic [`HCOP_SLEW_W-1:0] cfg_slew,
  // Events from the rest of the device
  input wire logic irq_status_rd,
  input wire logic light_sleep,
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic channel_assessment,
  input wire logic crc_valid,
  // Radio enable pin
  input wire logic radio_op_enable,
  // General pins
  input wire logic [GPIO_N-1:0] gpio_i,
  output logic [GPIO_N-1:0] gpio_o,
  output logic [GPIO_N-1:0] gpio_oe,
  // Interrupt pin
  output logic irq_o,
  output logic irq_oe,
  output logic irq_pullup_en,
  // Pad slew selects
  output logic slew_irq,
  output logic slew_clk,
  output logic slew_miso,
  output logic slew_gpio,
  // Clock pin and status
  output logic host_clock_output,
  output logic startup_done,
  output logic clk_locked,
  output logic activity_flag,
  output logic [GPIO_N-1:0] gpio_in_value
);
  // Parameter checks at elaboration; the clamp needs ten divide bits
  if (GPIO_N < 2) begin : g_bad_gpio_n
    $error("hcop_top: GPIO_N must be at least 2");
  end
  if (DIV_W < 10) begin : g_bad_div_w
    $error("hcop_top: DIV_W too narrow for the slowest clock");
  end
  if (STARTUP_CYCLES < 1) begin : g_bad_startup
    $error("hcop_top: STARTUP_CYCLES must be positive");
  end

  // Configuration registers
  logic [GPIO_N-1:0] dir_reg;
  logic [GPIO_N-1:0] lvl_reg;
  logic [1:0] func_reg;
  logic [DIV_W-1:0] div_reg;
  logic clk_en_reg;
  logic keep_reg;
  logic pullup_reg;
  logic [`HCOP_SLEW_W-1:0] slew_reg;

  // Sequencing and interrupt state
  hcop_state_e state_reg;
  hcop_state_e state_next;
  logic [31:0] start_cnt_reg;
  logic start_end;
  logic irq_pend_reg;
  logic irq_pend_next;

  // Pin synchronisers
  logic [GPIO_N-1:0] gin_s1_reg;
  logic [GPIO_N-1:0] gin_s2_reg;
  logic [GPIO_N-1:0] gin_val_reg;
  logic roe_s1_reg;
  logic roe_s2_reg;

  // Crossing to the link clock
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic req_reg;
  logic [DIV_W-1:0] sent_div_reg;
  logic sent_run_reg;
  logic want_run;
  logic xfer_idle;
  logic xfer_go;
  logic locked_reg;

  // Pin output registers
  logic [GPIO_N-1:0] gpio_o_reg;
  logic [GPIO_N-1:0] gpio_oe_reg;
  logic [GPIO_N-1:0] pin_lvl;
  logic [GPIO_N-1:0] pin_oe;
  logic act_reg;
  logic act_next;

  hcop_if #(.DIV_W(DIV_W)) cfg_link ();

  // Clamp divide to the slowest supported rate
  function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
    logic [DIV_W-1:0] lim;
    lim = DIV_W'(`HCOP_DIV_MAX);
    clamp_div = (d > lim) ? lim : ((d == '0) ? DIV_W'(1) : d);
  endfunction

  // Software written settings; reset leaves pins as inputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_reg <= GPIO_N'(`HCOP_GPIO_DIR_RESET); // R7
      lvl_reg <= GPIO_N'(`HCOP_GPIO_OUT_RESET);
      func_reg <= `HCOP_FUNC_RESET;
      div_reg <= DIV_W'(`HCOP_DIV_RESET); // R3
      clk_en_reg <= `HCOP_CLK_EN_RESET; // R3
      keep_reg <= `HCOP_KEEP_RESET;
      pullup_reg <= `HCOP_PULLUP_RESET;
      slew_reg <= `HCOP_SLEW_RESET;
    end else if (cfg_wr) begin
      dir_reg <= cfg_gpio_dir; // R11
      lvl_reg <= cfg_gpio_out; // R11
      func_reg <= cfg_gpio_func; // R10
      div_reg <= clamp_div(cfg_clk_div); // R1
      clk_en_reg <= cfg_clk_en;
      keep_reg <= cfg_sleep_keep; // R6
      pullup_reg <= cfg_irq_pullup; // R12
      slew_reg <= cfg_slew; // R13
    end
  end

  // Start-up interval and sleep tracking
  assign start_end = (start_cnt_reg == 32'(STARTUP_CYCLES - 1)); // R2
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HCOP_ST_STARTUP: begin
        if (start_end) begin
          state_next = HCOP_ST_IDLE; // R2
        end
      end
      HCOP_ST_IDLE: begin
        if (light_sleep) begin
          state_next = HCOP_ST_SLEEP;
        end
      end
      HCOP_ST_SLEEP: begin
        if (!light_sleep) begin
          state_next = HCOP_ST_IDLE;
        end
      end
      default: begin
        state_next = HCOP_ST_STARTUP;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= HCOP_ST_STARTUP;
      start_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == HCOP_ST_STARTUP) begin
        start_cnt_reg <= start_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Pending interrupt; a new event beats a same-cycle status read
  assign irq_pend_next = (state_reg == HCOP_ST_STARTUP && start_end) ||
                         (irq_pend_reg && !irq_status_rd); // R14
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_pend_reg <= 1'b0;
    end else begin
      irq_pend_reg <= irq_pend_next; // R2
    end
  end

  // Open drain: pulled low only while pending, never driven high
  assign irq_o = 1'b0; // R12
  assign irq_oe = irq_pend_reg; // R14
  assign irq_pullup_en = pullup_reg; // R12
  assign startup_done = (state_reg != HCOP_ST_STARTUP);

  // Slew selects go straight to the pads
  assign slew_irq = slew_reg[`HCOP_SLEW_IRQ]; // R13
  assign slew_clk = slew_reg[`HCOP_SLEW_CLK]; // R13
  assign slew_miso = slew_reg[`HCOP_SLEW_MISO]; // R13
  assign slew_gpio = slew_reg[`HCOP_SLEW_GPIO]; // R13

  // Pin inputs pass two flops before any use
  always_ff @(posedge ref_clk) begin
    gin_s1_reg <= gpio_i;
    gin_s2_reg <= gin_s1_reg;
    roe_s1_reg <= radio_op_enable;
    roe_s2_reg <= roe_s1_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gin_val_reg <= '0;
    end else begin
      gin_val_reg <= gin_s2_reg;
    end
  end
  assign gpio_in_value = gin_val_reg;

  // Status functions override pins one and two
  assign act_next = roe_s2_reg && (rx_busy || tx_busy || channel_assessment); // R15
  always_comb begin
    pin_lvl = lvl_reg;
    pin_oe = dir_reg; // R11
    if (func_reg[`HCOP_FUNC_ACT]) begin
      pin_lvl[0] = act_next; // R15
      pin_oe[0] = 1'b1; // R10
    end
    if (func_reg[`HCOP_FUNC_CRC]) begin
      pin_lvl[1] = crc_valid; // R16
      pin_oe[1] = 1'b1; // R10
    end
  end

  // Registered pin drive; there is no pull-up term on these pins at all
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gpio_o_reg <= '0;
      gpio_oe_reg <= '0; // R7
      act_reg <= 1'b0;
    end else begin
      gpio_o_reg <= pin_lvl & pin_oe;
      gpio_oe_reg <= pin_oe; // R8
      act_reg <= act_next;
    end
  end
  assign gpio_o = gpio_o_reg;
  assign gpio_oe = gpio_oe_reg;
  assign activity_flag = act_reg;

  // Clock runs after start-up, and in sleep only if kept
  assign want_run = clk_en_reg && (state_reg == HCOP_ST_IDLE ||
                    (state_reg == HCOP_ST_SLEEP && keep_reg)); // R5 R6

  // Settings cross by toggle handshake; held stable until acknowledged
  always_ff @(posedge ref_clk) begin
    ack_s1_reg <= cfg_link.ack_tgl;
    ack_s2_reg <= ack_s1_reg;
  end

  assign xfer_idle = (req_reg == ack_s2_reg);
  assign xfer_go = xfer_idle && ((sent_div_reg != div_reg) || (sent_run_reg != want_run));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_reg <= 1'b0;
      sent_div_reg <= DIV_W'(`HCOP_DIV_RESET);
      sent_run_reg <= 1'b0; // R5
      locked_reg <= 1'b0;
    end else begin
      if (xfer_go) begin
        req_reg <= !req_reg;
        sent_div_reg <= div_reg; // R1
        sent_run_reg <= want_run; // R6
      end
      locked_reg <= xfer_idle && !xfer_go && sent_run_reg;
    end
  end
  assign clk_locked = locked_reg;

  assign cfg_link.div_value = sent_div_reg;
  assign cfg_link.run = sent_run_reg;
  assign cfg_link.req_tgl = req_reg;

  // Divider on the reference clock
  hcop_clkdiv #(
    .DIV_W(DIV_W)
  ) u_clkdiv (
    .xtal_clk(xtal_clk),
    .rst(rst),
    .cfg(cfg_link),
    .host_clock_output(host_clock_output)
  );
endmodule // hcop_top

//--- verif/hcop_top_sva.sv
`timescale 1ns/100ps
// Port-level checks of start-up, interrupt and pin configuration
module hcop_top_sva #(
  parameter int GPIO_N = 7,
  parameter int STARTUP_CYCLES = 50
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration and events
  input wire logic cfg_wr,
  input wire logic [GPIO_N-1:0] cfg_gpio_dir,
  input wire logic [GPIO_N-1:0] cfg_gpio_out,
  input wire logic [1:0] cfg_gpio_func,
  input wire logic cfg_irq_pullup,
  input wire logic [3:0] cfg_slew,
  input wire logic irq_status_rd,
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic channel_assessment,
  // Observed outputs
  input wire logic [GPIO_N-1:0] gpio_o,
  input wire logic [GPIO_N-1:0] gpio_oe,
  input wire logic irq_o,
  input wire logic irq_oe,
  input wire logic irq_pullup_en,
  input wire logic slew_irq,
  input wire logic slew_clk,
  input wire logic host_clock_output,
  input wire logic startup_done,
  input wire logic activity_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  int unsigned since_rst_reg;

  // Cycles since reset release, saturating so it cannot wrap on long runs
  always_ff @(posedge ref_clk) begin
    if (rst) since_rst_reg <= 0;
    else if (since_rst_reg < STARTUP_CYCLES + 2) since_rst_reg <= since_rst_reg + 1;
  end

  a_startup_time: assert property ($rose(startup_done) |-> since_rst_reg == STARTUP_CYCLES)
    else $error("start-up ended at the wrong cycle");
  a_startup_irq: assert property ($rose(startup_done) |-> irq_oe)
    else $error("no interrupt at end of start-up");
  a_clock_held: assert property (!startup_done |-> !host_clock_output)
    else $error("clock pin toggling before start-up end");
  a_irq_release: assert property (irq_status_rd && startup_done |=> !irq_oe)
    else $error("interrupt not released by status read");
  a_irq_hold: assert property (irq_oe && !irq_status_rd |=> irq_oe)
    else $error("interrupt dropped without status read");
  a_irq_open_drain: assert property (irq_o == 1'b0)
    else $error("interrupt pin driven high");
  a_cfg_pads: assert property (cfg_wr |=> slew_irq == $past(cfg_slew[0])
    && slew_clk == $past(cfg_slew[1]) && irq_pullup_en == $past(cfg_irq_pullup))
    else $error("pad setting not taken from write");
  a_gpio_cfg: assert property (cfg_wr && cfg_gpio_func == 2'h0 |=> ##1
    gpio_oe == $past(cfg_gpio_dir, 2)
    && gpio_o == ($past(cfg_gpio_out, 2) & $past(cfg_gpio_dir, 2)))
    else $error("pin direction or level not taken from write");
  a_activity_cause: assert property (activity_flag |-> $past(rx_busy || tx_busy || channel_assessment))
    else $error("activity without a radio operation");
endmodule // hcop_top_sva

bind hcop_top hcop_top_sva #(.GPIO_N(GPIO_N), .STARTUP_CYCLES(STARTUP_CYCLES)) i_sva (.*);

//--- verif/hcop_host_model.sv
`timescale 1ns/100ps
// Host side of the pins: resolves the general pins and times the clock pin
module hcop_host_model #(
  parameter int GPIO_N = 7
) (
  // Reference clock
  input wire logic xtal_clk,
  // Device pins
  input wire logic [GPIO_N-1:0] gpio_o,
  input wire logic [GPIO_N-1:0] gpio_oe,
  input wire logic host_clock_output,
  input wire logic irq_o,
  input wire logic irq_oe,
  // Host drive
  input wire logic [GPIO_N-1:0] host_drv,
  input wire logic [GPIO_N-1:0] host_oe,
  // Observed levels
  output logic [GPIO_N-1:0] gpio_i,
  output logic irq_n,
  output int high_len,
  output int rise_cnt
);
  logic [GPIO_N-1:0] float_reg = '0;
  logic last_reg = 1'b0;
  int run_reg = 0;

  // Nobody pulls an undriven pin, so it wanders every cycle
  always @(posedge xtal_clk) float_reg <= ~float_reg;
  assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & host_oe & host_drv)
    | (~gpio_oe & ~host_oe & float_reg);
  // Host keeps its own pull-up on the released line
  assign irq_n = irq_oe ? irq_o : 1'b1;

  initial begin
    high_len = 0;
    rise_cnt = 0;
  end
  // High phase in reference cycles, latched at each fall
  always @(posedge xtal_clk) begin
    last_reg <= host_clock_output;
    run_reg <= host_clock_output ? run_reg + 1 : 0;
    if (last_reg && !host_clock_output) high_len <= run_reg;
    if (!last_reg && host_clock_output) rise_cnt <= rise_cnt + 1;
  end
endmodule // hcop_host_model

//--- verif/hcop_top_bench.sv
`timescale 1ns/100ps
`include "hcop_params.svh"
// Self-checking bench for the pin and clock block
module hcop_top_bench;
  import hcop_pkg::*;
  localparam int SC = 50;
  logic ref_clk = 0, xtal_clk = 0, rst = 1, cfg_wr = 0, cfg_clk_en = 1;
  hcop_gpio_t cfg_gpio_dir = '0, cfg_gpio_out = '0, host_drv = '0, host_oe = '0;
  hcop_gpio_t gpio_i, gpio_o, gpio_oe, gpio_in_value;
  hcop_div_t cfg_clk_div = `HCOP_DIV_RESET;
  logic [1:0] cfg_gpio_func = '0;
  logic [3:0] cfg_slew = '0;
  logic cfg_sleep_keep = 0, cfg_irq_pullup = 1, irq_status_rd = 0, light_sleep = 0;
  logic rx_busy = 0, tx_busy = 0, channel_assessment = 0, crc_valid = 0, radio_op_enable = 0;
  logic irq_o, irq_oe, irq_pullup_en, slew_irq, slew_clk, slew_miso, slew_gpio, irq_n;
  logic host_clock_output, startup_done, clk_locked, activity_flag;
  int high_len, rise_cnt, n_errors = 0, checks = 0, cyc = 0;

  hcop_top #(.STARTUP_CYCLES(SC)) i_dut (.*);
  hcop_host_model i_host (.*);

  // Clocks with unrelated phase
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #13;
    forever #40 xtal_clk = ~xtal_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      end_of_test;
    end
  end

  task automatic wr;
    cfg_wr <= 1;
    @(posedge ref_clk);
    cfg_wr <= 0;
    repeat (3) @(negedge ref_clk);
  endtask

  // Reset long enough for the divider domain too
  task automatic t_reset;
    @(posedge ref_clk);
    rst <= 1;
    repeat (100) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("gpio_oe", gpio_oe, 0);
    chk("irq_n", irq_n, 1);
    chk("pullup", irq_pullup_en, 1);
    chk("clock", host_clock_output, 0);
    @(posedge ref_clk);
    rst <= 0;
  endtask

  task automatic t_startup;
    int i, r0;
    @(negedge ref_clk);
    for (i = 0; i < 2 * SC && startup_done !== 1'b1; i++) @(negedge ref_clk);
    chk("startup", i, SC);
    chk("irq_n", irq_n, 0);
    for (i = 0; i < 20000 && clk_locked !== 1'b1; i++) @(negedge ref_clk);
    r0 = rise_cnt;
    for (i = 0; i < 12000 && rise_cnt == r0; i++) @(negedge ref_clk);
    chk("clock runs", rise_cnt > r0, 1);
  endtask

  task automatic t_period(input string what, input int exp);
    int i, r0;
    for (i = 0; i < 20000 && clk_locked !== 1'b1; i++) @(negedge ref_clk);
    r0 = rise_cnt;
    for (i = 0; i < 40000 && rise_cnt < r0 + 3; i++) @(negedge ref_clk);
    chk(what, high_len, exp);
  endtask

  task automatic t_irq;
    repeat (5) @(negedge ref_clk);
    chk("irq held", irq_n, 0);
    @(posedge ref_clk);
    irq_status_rd <= 1;
    @(posedge ref_clk);
    irq_status_rd <= 0;
    @(negedge ref_clk);
    chk("irq released", irq_n, 1);
  endtask

  // Each slew select alone, pull-up toggled alongside
  task automatic t_pads;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      cfg_slew <= 4'h1 << i;
      cfg_irq_pullup <= i[0];
      wr;
      chk("slew", {slew_gpio, slew_miso, slew_clk, slew_irq}, 4'h1 << i);
      chk("pullup", irq_pullup_en, i[0]);
    end
  endtask

  // Unused pins parked low, then mixed directions against host drive
  task automatic t_gpio;
    @(posedge ref_clk);
    cfg_gpio_dir <= 7'h7f;
    wr;
    chk("park oe", gpio_oe, 7'h7f);
    chk("park out", gpio_o, 7'h00);
    @(posedge ref_clk);
    cfg_gpio_dir <= 7'h55;
    cfg_gpio_out <= 7'h14;
    host_oe <= 7'h2a;
    host_drv <= 7'h2a;
    wr;
    repeat (4) @(negedge ref_clk);
    chk("mix oe", gpio_oe, 7'h55);
    chk("mix out", gpio_o, 7'h14);
    chk("pin in", gpio_in_value, 7'h3e);
  endtask

  // Status functions on pins one and two for each operation kind
  task automatic t_status;
    logic [2:0] op;
    @(posedge ref_clk);
    cfg_gpio_func <= 2'h3;
    radio_op_enable <= 1;
    wr;
    for (int i = 0; i < 4; i++) begin
      op = 3'h4 >> i;
      @(posedge ref_clk);
      {rx_busy, tx_busy, channel_assessment} <= op;
      crc_valid <= op[2]; // Differs from activity for tx and cca
      repeat (8) @(negedge ref_clk);
      chk("status oe", gpio_oe[1:0], 2'h3);
      chk("activity", gpio_o[0], |op);
      chk("activity flag", activity_flag, |op);
      chk("crc", gpio_o[1], op[2]);
    end
    @(posedge ref_clk);
    cfg_gpio_func <= 2'h0;
    wr;
  endtask

  // Light sleep stops the clock unless keep is chosen
  task automatic t_sleep(input logic k);
    int r0;
    @(posedge ref_clk);
    cfg_sleep_keep <= k;
    light_sleep <= 1;
    wr;
    repeat (1000) @(negedge ref_clk);
    r0 = rise_cnt;
    repeat (1000) @(negedge ref_clk);
    chk("sleep clock", rise_cnt > r0, k);
    @(posedge ref_clk);
    light_sleep <= 0;
  endtask

  // Clearing the enable stops the pin, setting it again restarts it
  task automatic t_clk_off;
    int r0;
    @(posedge ref_clk);
    cfg_clk_en <= 0;
    wr;
    repeat (1000) @(negedge ref_clk);
    r0 = rise_cnt;
    repeat (1000) @(negedge ref_clk);
    chk("clock off", rise_cnt > r0, 0);
    @(posedge ref_clk);
    cfg_clk_en <= 1;
    wr;
    repeat (1000) @(negedge ref_clk);
    r0 = rise_cnt;
    repeat (1000) @(negedge ref_clk);
    chk("clock back", rise_cnt > r0, 1);
  endtask

  task automatic t_divide(input hcop_div_t n);
    @(posedge ref_clk);
    cfg_clk_div <= n;
    wr;
    t_period("high phase", n / 2);
  endtask

  // Host sequence: reset, wait for start-up, reprogram, then Off and back
  initial begin
    t_reset;
    t_startup;
    t_period("default high", `HCOP_DIV_RESET / 2);
    t_irq;
    t_pads;
    t_gpio;
    t_status;
    t_divide(10'h007);
    t_divide(10'h014);
    t_sleep(0);
    t_sleep(1);
    t_clk_off;
    t_reset;
    t_startup;
    end_of_test;
  end
endmodule // hcop_top_bench
